// ### design/receive_front_end.sv
// receive shift register and hand-off, clocked by the receive clock pin
`timescale 1ns/1ps

module receive_front_end
  import serial_port_pkg::*;
(
  input  wire logic        receive_clock_pin,  // link bit clock, always an input
  input  wire logic        resetn,             // asynchronous, active low
  input  wire logic        frame_sync,         // receive frame sync, on this clock
  input  wire logic        data_in,            // receive data pin
  input  wire logic [1:0]  length_sel,         // word length field, quasi-static
  input  wire logic        ack_toggle,         // hand-off acknowledge, other domain
  output logic      [31:0] word,               // handed-off word
  output logic             req_toggle          // flips once per handed-off word
);

  rx_state_t st;       // registered state
  rx_state_t next_st;  // next state
  logic      pending;  // previous word not yet taken by the processor side

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.ack_s1 = ack_toggle;
    next_st.ack_s2 = st.ack_s1;
    next_st.len_s1 = length_sel;
    next_st.len_s2 = st.len_s1;
    pending = (st.req != st.ack_s2);
    if (st.full)
    begin
      // frozen: input bits and frame syncs are ignored until the buffer frees
      if (!pending)
      begin
        next_st.hold = st.shift;
        next_st.req  = ~st.req;
        next_st.full = 1'b0;
      end
    end
    else if (st.active)
    begin
      // data pin into the shift register, msb first
      next_st.shift = {st.shift[30:0], data_in};
      next_st.count = st.count + 6'h01;
      if (next_st.count == word_bits(st.len_s2))
      begin
        next_st.active = 1'b0;
        if (pending)
          next_st.full = 1'b1;
        else
        begin
          // full word goes to the buffer side
          next_st.hold = {st.shift[30:0], data_in};
          next_st.req  = ~st.req;
        end
      end
    end
    else if (frame_sync)
    begin
      // a frame sync pulse while no frame is active and the buffer is not full opens a new frame
      next_st.active = 1'b1;
      next_st.count  = 6'h00;
      next_st.shift  = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // state register; the clock may stop between frames, so the hand-off is a
  // level toggle that needs no further edge here once sent
  // ----------------------------------------------------------------------------
  always_ff @(posedge receive_clock_pin or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign word       = st.hold;
  assign req_toggle = st.req;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  a_rx_frozen_hold: assert property (@(posedge receive_clock_pin) disable iff (!resetn)
    st.full && (st.req != st.ack_s2) |=> $stable(st.shift) && !st.active)
    else $error("receive shift register changed while frozen");

  a_rx_frame_start: assert property (@(posedge receive_clock_pin) disable iff (!resetn)
    !st.active && !st.full && frame_sync |=> st.active && st.count == 6'h00)
    else $error("frame sync did not open a frame");

endmodule

// ### design/serial_port.sv
// standard bidirectional serial port with double-buffered transmit and receive
`timescale 1ns/1ps

`include "serial_port_defines.svh"

// Contract
// - adc word: 4 control, 12 data bits
// - adc interrupt cancelled by first falling edge
// - adc result shifts into receive data pin
// - dac word 16 bits, fields msb first
// - transmit clock pin output when internal
// - transmit frame sync output when internal
// - receive clock always input, shifts data
// - receive frame sync starts each frame
// - registers 32 bits, shifters unaddressed
// - buffer loads shifter only when empty
// - load into shifter sets transmit ready
// - transmit ready rise sets flag, both enables
// - full word copies to buffer, sets ready
// - unread buffer freezes receiver, no overwrite
// - receive ready rise sets flag, both enables
module serial_port
  import serial_port_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = `BIT_CLK_HALF_CYCLES  // bit clock half period
)
(
  input  wire logic        mclk,                     // processor clock
  input  wire logic        resetn,                   // asynchronous, active low
  input  wire bus_req_t    bus,                      // register access
  output logic      [31:0] bus_rdata,                // read data, one cycle after read
  input  wire logic        transmit_clock_pin_in,    // external bit clock
  output logic             transmit_clock_pin_out,   // generated bit clock
  output logic             transmit_clock_pin_oe,    // high while driving
  input  wire logic        transmit_frame_sync_in,   // external frame sync
  output logic             transmit_frame_sync_out,  // generated frame sync
  output logic             transmit_frame_sync_oe,   // high while driving
  output logic             transmit_data_pin,        // serial data out
  input  wire logic        receive_clock_pin,        // receive bit clock
  input  wire logic        receive_frame_sync,       // receive frame sync
  input  wire logic        receive_data_pin,         // serial data in
  input  wire logic        flag_request,             // value for the flag pin
  output logic             general_flag_output,      // general purpose flag pin
  input  wire logic        cpu_transmit_irq_enable,  // processor level enable
  input  wire logic        cpu_receive_irq_enable,   // processor level enable
  input  wire logic [1:0]  irq_flag_clear,           // pulse: bit0 transmit, bit1 receive
  output logic             transmit_irq_flag,        // sticky flag
  output logic             receive_irq_flag          // sticky flag
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);  // last divider count

  port_state_t st;        // registered state
  port_state_t next_st;   // next state
  logic [31:0] rx_word;   // word from the receive front end
  logic        rx_req;    // receive hand-off toggle
  logic        clk_int;   // bit clock generated here
  logic        fs_int;    // frame sync generated here
  logic        fall;      // falling edge of the bit clock, one cycle
  logic        wr_txbuf;  // write to transmit_buffer
  logic        rd_rbuf;   // read of receive_buffer
  logic [5:0]  tx_bits;   // transmit word length
  logic [5:0]  tx_shamt;  // left alignment of a transmit word

  // ----------------------------------------------------------------------------
  // receive front end on the receive clock
  // ----------------------------------------------------------------------------
  receive_front_end u_rx (
    .receive_clock_pin (receive_clock_pin),
    .resetn            (resetn),
    .frame_sync        (receive_frame_sync),
    .data_in           (receive_data_pin),
    .length_sel        (st.glob[`GC_RX_LEN_LSB +: 2]),
    .ack_toggle        (st.ack),
    .word              (rx_word),
    .req_toggle        (rx_req)
  );

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    next_st  = st;
    clk_int  = st.glob[`GC_CLK_INTERNAL_BIT];
    fs_int   = st.glob[`GC_FS_INTERNAL_BIT];
    tx_bits  = word_bits(st.glob[`GC_TX_LEN_LSB +: 2]);
    tx_shamt = 6'd32 - tx_bits;
    wr_txbuf = bus.write && (bus.addr == `ADDR_TRANSMIT_BUFFER);
    rd_rbuf  = bus.read && (bus.addr == `ADDR_RECEIVE_BUFFER);
    fall     = 1'b0;

    // pin synchronisers; the second stages, and tclk_s3 for the clock edge, are read below
    next_st.tclk_s1 = transmit_clock_pin_in;
    next_st.tclk_s2 = st.tclk_s1;
    next_st.tclk_s3 = st.tclk_s2;
    next_st.fsx_s1  = transmit_frame_sync_in;
    next_st.fsx_s2  = st.fsx_s1;
    next_st.req_s1  = rx_req;
    next_st.req_s2  = st.req_s1;
    next_st.flag    = flag_request;

    // bit clock: divided from mclk when internal, else edges of the pin
    if (clk_int)
    begin
      if (st.div_cnt == HALF_LAST)
      begin
        next_st.div_cnt  = 8'h00;
        next_st.tclk_out = ~st.tclk_out;
        fall             = st.tclk_out;
      end
      else
        next_st.div_cnt = st.div_cnt + 8'h01;
    end
    else
    begin
      next_st.div_cnt  = 8'h00;
      next_st.tclk_out = 1'b0;
      fall             = st.tclk_s3 && !st.tclk_s2;
    end

    // transmit sequencer, outputs change on the falling bit clock edge
    if (fall)
    begin
      case (st.tx_state)
        TX_IDLE:
        begin
          next_st.fsx_out = 1'b0;
          // frame sync from here when internal, else from the pin
          if (st.xsr_full && (fs_int || st.fsx_s2))
          begin
            next_st.fsx_out  = fs_int;
            next_st.tx_state = TX_SYNC;
          end
        end
        TX_SYNC:
        begin
          // first bit out as the frame sync drops, msb first
          next_st.fsx_out  = 1'b0;
          next_st.dx_out   = st.transmit_shift_reg[31];
          next_st.transmit_shift_reg      = {st.transmit_shift_reg[30:0], 1'b0};
          next_st.bit_cnt  = 6'h01;
          next_st.tx_state = TX_SHIFT;
        end
        TX_SHIFT:
        begin
          if (st.bit_cnt == tx_bits)
          begin
            next_st.xsr_full = 1'b0;
            next_st.tx_state = TX_IDLE;
          end
          else
          begin
            next_st.dx_out  = st.transmit_shift_reg[31];
            next_st.transmit_shift_reg     = {st.transmit_shift_reg[30:0], 1'b0};
            next_st.bit_cnt = st.bit_cnt + 6'h01;
          end
        end
        default:
          next_st.tx_state = TX_IDLE;
      endcase
    end

    // register writes; the status bits of the global word are stored, but reads return the ready flags in their place
    if (bus.write)
    begin
      case (bus.addr)
        `ADDR_SERIAL_GLOBAL_CONTROL: next_st.glob = bus.wdata;
        `ADDR_TRANSMIT_PIN_CONTROL:  next_st.txpc = bus.wdata;
        `ADDR_RECEIVE_PIN_CONTROL:   next_st.rxpc = bus.wdata;
        `ADDR_PORT_TIMER_CONTROL:    next_st.tctl = bus.wdata;
        `ADDR_PORT_TIMER_COUNT:      next_st.tcnt = bus.wdata;
        `ADDR_PORT_TIMER_PERIOD:     next_st.tper = bus.wdata;
        `ADDR_TRANSMIT_BUFFER:
        begin
          next_st.txbuf   = bus.wdata;
          next_st.tx_full = 1'b1;
          next_st.transmit_ready    = 1'b0;
        end
        default: ;  // unmapped and read-only addresses ignore writes
      endcase
    end

    // buffer into shifter only once the shifter has emptied the move waits for
    // the registered buffer, so ready drops for a cycle and its rise is always seen
    if (st.tx_full && !next_st.xsr_full)
    begin
      next_st.transmit_shift_reg      = st.txbuf << tx_shamt;
      next_st.xsr_full = 1'b1;
      next_st.tx_full  = wr_txbuf;   // a word written now stays buffered
      next_st.transmit_ready     = !wr_txbuf;
    end

    // reading receive_buffer frees it
    if (rd_rbuf)
      next_st.receive_ready = 1'b0;

    // take a received word only into a free buffer, never over one
    if ((st.req_s2 != st.ack) && !next_st.receive_ready)
    begin
      next_st.rbuf = rx_word;
      next_st.receive_ready = 1'b1;
      next_st.ack  = ~st.ack;
    end

    // interrupt flags: clear first so that a same-cycle rise still sets
    if (irq_flag_clear[0])
      next_st.xirq = 1'b0;
    if (next_st.transmit_ready && !st.transmit_ready && st.glob[`GC_TX_IRQ_EN_BIT] && cpu_transmit_irq_enable)
      next_st.xirq = 1'b1;
    if (irq_flag_clear[1])
      next_st.rirq = 1'b0;
    if (next_st.receive_ready && !st.receive_ready && st.glob[`GC_RX_IRQ_EN_BIT] && cpu_receive_irq_enable)
      next_st.rirq = 1'b1;

    // registered read data, unmapped addresses read zero
    if (bus.read)
    begin
      case (bus.addr)
        `ADDR_SERIAL_GLOBAL_CONTROL:
          next_st.rdata = {st.glob[31:2], st.receive_ready, st.transmit_ready};
        `ADDR_TRANSMIT_PIN_CONTROL: next_st.rdata = st.txpc;
        `ADDR_RECEIVE_PIN_CONTROL:  next_st.rdata = st.rxpc;
        `ADDR_PORT_TIMER_CONTROL:   next_st.rdata = st.tctl;
        `ADDR_PORT_TIMER_COUNT:     next_st.rdata = st.tcnt;
        `ADDR_PORT_TIMER_PERIOD:    next_st.rdata = st.tper;
        `ADDR_TRANSMIT_BUFFER:      next_st.rdata = st.txbuf;
        `ADDR_RECEIVE_BUFFER:       next_st.rdata = st.rbuf;
        default:                    next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // state register; transmit_ready starts high because the buffer is empty
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st       <= '0;
      st.transmit_ready  <= 1'b1;
      st.glob  <= `REG_RESET_VALUE;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------------
  assign bus_rdata               = st.rdata;
  assign transmit_clock_pin_out  = st.tclk_out;
  assign transmit_clock_pin_oe   = st.glob[`GC_CLK_INTERNAL_BIT];
  assign transmit_frame_sync_out = st.fsx_out;
  assign transmit_frame_sync_oe  = st.glob[`GC_FS_INTERNAL_BIT];
  assign transmit_data_pin       = st.dx_out;
  assign general_flag_output     = st.flag;
  assign transmit_irq_flag       = st.xirq;
  assign receive_irq_flag        = st.rirq;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // all checks here are on the processor clock; the receive clock checks sit in
  // the front end, beside the shift register they watch

  a_tx_load_empty: assert property (
    st.xsr_full && st.tx_full && !(fall && st.tx_state == TX_SHIFT) |=> st.tx_full)
    else $error("buffered word moved into a busy shift register");

  a_tx_ready_set: assert property (
    $rose(st.xsr_full) |-> st.transmit_ready && !st.tx_full)
    else $error("transmit ready not set on load");

  a_tx_irq_gate: assert property (
    $rose(st.xirq) |-> $rose(st.transmit_ready) && $past(st.glob[`GC_TX_IRQ_EN_BIT])
      && $past(cpu_transmit_irq_enable))
    else $error("transmit flag set without rise or enables");

  a_tx_irq_edge: assert property (
    $rose(st.transmit_ready) && $past(st.glob[`GC_TX_IRQ_EN_BIT] && cpu_transmit_irq_enable)
      |-> st.xirq)
    else $error("transmit flag missed a ready rise");

  a_rx_no_over: assert property (
    st.receive_ready && !rd_rbuf |=> $stable(st.rbuf) && st.receive_ready)
    else $error("receive buffer overwritten while unread");

  a_rx_ready_set: assert property (
    (st.req_s2 != st.ack) && !st.receive_ready |=> st.receive_ready && $changed(st.ack))
    else $error("received word not moved to buffer");

  a_rx_irq_edge: assert property (
    $rose(st.receive_ready) && $past(st.glob[`GC_RX_IRQ_EN_BIT] && cpu_receive_irq_enable)
      |-> st.rirq)
    else $error("receive flag missed a ready rise");

  a_tx_first_bit: assert property (
    st.tx_state == TX_SYNC && fall |=> st.dx_out == $past(st.transmit_shift_reg[31])
      && st.bit_cnt == 6'h01 && !st.fsx_out)
    else $error("first transmit bit not the msb");

  a_fs_pulse: assert property (
    $rose(st.fsx_out) |-> st.tx_state == TX_SYNC && st.xsr_full)
    else $error("frame sync without a word to send");

  a_fs_one_bit: assert property (
    st.fsx_out && fall |=> !st.fsx_out)
    else $error("frame sync longer than one bit period");

  a_rx_irq_gate: assert property (
    $rose(st.rirq) |-> $rose(st.receive_ready) && $past(st.glob[`GC_RX_IRQ_EN_BIT])
      && $past(cpu_receive_irq_enable))
    else $error("receive flag set without rise or enables");

  a_rx_read_data: assert property (
    bus.read && bus.addr == `ADDR_RECEIVE_BUFFER |=> st.rdata == $past(st.rbuf))
    else $error("receive buffer read returned a stale word");

  a_rx_read_free: assert property (
    rd_rbuf && (st.req_s2 == st.ack) |=> !st.receive_ready)
    else $error("receive buffer still busy after a read");

  a_tx_frame_end: assert property (
    fall && st.tx_state == TX_SHIFT && st.bit_cnt == tx_bits |=> st.tx_state == TX_IDLE)
    else $error("transmit frame ran past its word length");

  a_tx_ready_clear: assert property (
    wr_txbuf && !st.tx_full |=> !st.transmit_ready && st.tx_full)
    else $error("buffered transmit word left ready set");

endmodule

// ### design/serial_port_defines.svh
// register map, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// ----------------------------------------------------------------------------
// word addresses of the memory-mapped registers
// ----------------------------------------------------------------------------
`define ADDR_SERIAL_GLOBAL_CONTROL 24'h808040
`define ADDR_TRANSMIT_PIN_CONTROL  24'h808042
`define ADDR_RECEIVE_PIN_CONTROL   24'h808043
`define ADDR_PORT_TIMER_CONTROL    24'h808044
`define ADDR_PORT_TIMER_COUNT      24'h808045
`define ADDR_PORT_TIMER_PERIOD     24'h808046
`define ADDR_TRANSMIT_BUFFER       24'h808048
`define ADDR_RECEIVE_BUFFER        24'h80804C

// ----------------------------------------------------------------------------
// serial_global_control field positions
// ----------------------------------------------------------------------------
`define GC_TX_READY_BIT      0
`define GC_RX_READY_BIT      1
`define GC_FS_INTERNAL_BIT   2
`define GC_CLK_INTERNAL_BIT  6
`define GC_TX_LEN_LSB        18
`define GC_RX_LEN_LSB        20
`define GC_TX_IRQ_EN_BIT     26
`define GC_RX_IRQ_EN_BIT     27

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define REG_RESET_VALUE      32'h0000_0000
`define MCLK_PERIOD_NS       8
`define BIT_CLK_PERIOD_NS    160
`define BIT_CLK_HALF_CYCLES  ((`BIT_CLK_PERIOD_NS / `MCLK_PERIOD_NS) / 2)

`endif

// ### design/serial_port_pkg.sv
// types shared by the serial port modules
package serial_port_pkg;

  // ----------------------------------------------------------------------------
  // processor-side register access
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [23:0] addr;   // word address
    logic        write;  // one-cycle write strobe
    logic        read;   // one-cycle read strobe
    logic [31:0] wdata;  // write data
  } bus_req_t;

  // transmit sequencer states
  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_SHIFT} tx_state_t;

  // ----------------------------------------------------------------------------
  // receive front end state, receive clock domain
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] shift;   // receive shift register, not addressable
    logic [31:0] hold;    // word handed across to the processor clock
    logic [5:0]  count;   // bits taken in this frame
    logic        active;  // frame in progress
    logic        full;    // shift register full and frozen
    logic        req;     // hand-off toggle
    logic        ack_s1;  // ack synchroniser, first stage
    logic        ack_s2;  // ack synchroniser, second stage
    logic [1:0]  len_s1;  // word length synchroniser
    logic [1:0]  len_s2;
  } rx_state_t;

  // ----------------------------------------------------------------------------
  // port state, processor clock domain
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] glob;     // serial_global_control storage
    logic [31:0] txpc;     // transmit_pin_control
    logic [31:0] rxpc;     // receive_pin_control
    logic [31:0] tctl;     // port_timer_control
    logic [31:0] tcnt;     // port_timer_count
    logic [31:0] tper;     // port_timer_period
    logic [31:0] txbuf;    // transmit_buffer
    logic [31:0] transmit_shift_reg;      // transmit shift register, left aligned
    logic [31:0] rbuf;     // receive_buffer
    logic [31:0] rdata;    // registered read data
    logic        tx_full;  // transmit_buffer holds an unsent word
    logic        xsr_full; // shift register holds a word
    logic        transmit_ready;     // transmit_ready
    logic        receive_ready;     // receive_ready
    logic        xirq;     // transmit_irq_flag
    logic        rirq;     // receive_irq_flag
    tx_state_t   tx_state;
    logic [5:0]  bit_cnt;  // bits sent in this frame
    logic [7:0]  div_cnt;  // bit clock divider
    logic        tclk_out; // generated bit clock
    logic        fsx_out;  // generated frame sync
    logic        dx_out;   // transmit data
    logic        tclk_s1;  // external clock synchroniser
    logic        tclk_s2;
    logic        tclk_s3;  // edge detect stage
    logic        fsx_s1;   // external frame sync synchroniser
    logic        fsx_s2;
    logic        req_s1;   // receive hand-off synchroniser
    logic        req_s2;
    logic        ack;      // receive hand-off acknowledge toggle
    logic        flag;     // general purpose flag
  } port_state_t;

  // bits per word from a two-bit length field: 8, 16, 24 or 32
  function automatic logic [5:0] word_bits(input logic [1:0] len);
    word_bits = {len + 2'b01 == 2'b00 ? 1'b1 : 1'b0, len + 2'b01, 3'b000};
  endfunction

endpackage

// ### test/converter_model.sv
// behavioural converter pair on the far side of the serial port
`timescale 1ns/1ps

module converter_model
(
  input  wire logic        sclk,  // shared bit clock
  input  wire logic        fs,    // frame sync from the port
  input  wire logic        cs_n,  // adc select, active low
  input  wire logic        din,   // port transmit data
  output logic             dout,  // result bits into the port
  output logic      [15:0] cap    // last word shifted in
);
  logic [15:0] res = 16'h0C35;  // result held for the next frame
  logic [15:0] sr  = 16'h0000;  // result being shifted out
  logic [4:0]  cnt = 5'h00;     // bits left in this frame
  initial dout = 1'h0;
  initial cap = 16'h0000;
  // frame start and word capture on rising edges
  always @(posedge sclk)
    if (fs)
    begin
      sr  <= res;
      res <= res + 16'h0111;  // a new frame shifts out the held result and holds the next one
      cnt <= 5'h10;
    end
    else if (cnt != 5'h00)
    begin
      cap <= {cap[14:0], din};
      cnt <= cnt - 5'h01;
    end
  // result changes on falling edges; undriven line toggles so it never looks valid
  always @(negedge sclk)
    dout <= (cnt != 5'h00 && !cs_n) ? sr[cnt - 5'h01] : ~dout;
endmodule

// ### test/tb.sv
// self-checking bench of the serial port against the converter model
`timescale 1ns/1ps
`include "serial_port_defines.svh"

module tb
  import serial_port_pkg::*;
;
  logic mclk = 1'h0, resetn = 1'h0, tclk, tclk_oe, tfs, tfs_oe, dx, din, flag;
  logic flag_req = 1'h0, tx_en = 1'h0, rx_en = 1'h0, tx_irq, rx_irq;
  logic [1:0]  clr = 2'h0;  // flag clear pulses
  bus_req_t    bus = '0;    // register access
  logic [31:0] bus_rdata, d;
  logic [15:0] cap;         // word seen by the converters
  int failures = 0, n_checks = 0, cycles = 0;
  always #4 mclk = ~mclk;
  // bit clock and frame sync looped back to the receiver, as on the board
  serial_port serial_port_i (.mclk(mclk), .resetn(resetn), .bus(bus),
    .bus_rdata(bus_rdata), .transmit_clock_pin_in(1'h0), .transmit_clock_pin_out(tclk),
    .transmit_clock_pin_oe(tclk_oe), .transmit_frame_sync_in(1'h0),
    .transmit_frame_sync_out(tfs), .transmit_frame_sync_oe(tfs_oe), .transmit_data_pin(dx),
    .receive_clock_pin(tclk), .receive_frame_sync(tfs), .receive_data_pin(din),
    .flag_request(flag_req), .general_flag_output(flag), .cpu_transmit_irq_enable(tx_en),
    .cpu_receive_irq_enable(rx_en), .irq_flag_clear(clr), .transmit_irq_flag(tx_irq),
    .receive_irq_flag(rx_irq));
  converter_model converter_model_i (.sclk(tclk), .fs(tfs), .cs_n(flag), .din(dx),
    .dout(din), .cap(cap));
  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard: the whole run needs about sixteen hundred cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus <= '{a, 1'h1, 1'h0, v};
    @(posedge mclk);
    bus.write <= 1'h0;
  endtask
  task automatic rd(input logic [23:0] a, output logic [31:0] v);
    @(posedge mclk);
    bus <= '{a, 1'h0, 1'h1, 32'h0};
    @(posedge mclk);
    bus.read <= 1'h0;
    @(negedge mclk);
    v = bus_rdata;
  endtask
  // setup values, readback, an unmapped hole and the status bits
  task automatic check_registers();
    wr(`ADDR_SERIAL_GLOBAL_CONTROL, 32'h0C140044);
    wr(`ADDR_TRANSMIT_PIN_CONTROL, 32'h00000111);
    wr(`ADDR_RECEIVE_PIN_CONTROL, 32'h00000111);
    wr(`ADDR_PORT_TIMER_CONTROL, 32'h000001CF);
    rd(`ADDR_PORT_TIMER_CONTROL, d);
    chk("timer control", d, 32'h000001CF);
    rd(24'h808041, d);
    chk("unmapped", d, 32'h0);
    rd(`ADDR_SERIAL_GLOBAL_CONTROL, d);
    chk("global", d, 32'h0C140045);
    chk("clock drive", tclk_oe, 32'h1);
    chk("sync drive", tfs_oe, 32'h1);
  endtask
  // one full frame out and back, with both flags
  task automatic check_single_frame();
    @(posedge mclk);
    tx_en <= 1'h1;
    rx_en <= 1'h1;
    chk("tx flag idle", tx_irq, 32'h0);
    wr(`ADDR_TRANSMIT_BUFFER, 32'h0000A5C3);
    repeat (2) @(posedge mclk);
    #1 chk("tx flag", tx_irq, 32'h1);
    repeat (400) @(posedge mclk);
    chk("dac word", cap, 32'hA5C3);
    chk("rx flag", rx_irq, 32'h1);
    rd(`ADDR_SERIAL_GLOBAL_CONTROL, d);
    chk("rx ready", d[1], 32'h1);
    rd(`ADDR_RECEIVE_BUFFER, d);
    chk("rx word", d, 32'h00000C35);
    @(posedge mclk);
    clr <= 2'h3;
    @(posedge mclk);
    clr <= 2'h0;
  endtask
  // bring-up words with the buffer left unread: no received word is overwritten
  task automatic check_receiver_freeze();
    wr(`ADDR_TRANSMIT_BUFFER, 32'h0000A000);
    wr(`ADDR_TRANSMIT_BUFFER, 32'h0000A000);
    repeat (400) @(posedge mclk);
    wr(`ADDR_TRANSMIT_BUFFER, 32'h00003333);
    repeat (700) @(posedge mclk);
    chk("last word out", cap, 32'h3333);
    rd(`ADDR_RECEIVE_BUFFER, d);
    chk("held word", d, 32'h00000D46);
    repeat (40) @(posedge mclk);
    rd(`ADDR_RECEIVE_BUFFER, d);
    chk("frozen word", d, 32'h00000E57);
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    resetn <= 1'h1;
    check_registers();
    check_single_frame();
    check_receiver_freeze();
    end_of_test();
  end
endmodule
